// File: acc_compare_map.vh
`ifndef ACC_COMPARE_MAP_VH
`define ACC_COMPARE_MAP_VH
// Register byte offsets
`define REG_CTRL      8'h00
`define REG_OPERAND   8'h04
`define REG_BITFIELD  8'h08
`define REG_ACC       8'h0C
`define REG_STACK_TOP 8'h10
`define REG_STATUS    8'h14
`define REG_IRQ_STAT  8'h18
`define REG_IRQ_MASK  8'h1C
`define REG_STACK_D1  8'h20
// Control register opcodes (bits 2:0, written with start)
`define OP_NONE       3'h0
`define OP_WORD       3'h1
`define OP_DOUBLE     3'h2
`define OP_BITFIELD   3'h3
`define OP_STACK      3'h4
`define OP_LOAD       3'h5
`define CTRL_OP_MSB   2
`define CTRL_OP_LSB   0
// Bitfield control fields
`define BF_START_MSB  4
`define BF_START_LSB  0
`define BF_CNT_MSB    13
`define BF_CNT_LSB    8
`define BF_CNT_MIN    6'h01
`define BF_CNT_MAX    6'h20
`define BF_RESET      14'h0001
// Flag positions
`define FLG_LT        0
`define FLG_EQ        1
`define FLG_GT        2
`define FLG_BAD       3
// Interrupt event positions
`define EVT_DONE      0
`define EVT_BADCNT    1
// Widths and reset values
`define WORD_W        16
`define ACC_W         32
`define STACK_DEPTH   8
`define ZERO32        32'h00000000
`endif

// File: accumulator_compare_unit.v
// Operation
// RULE_01 - Word compare uses accumulator low 16 bits
// RULE_02 - Less-than flag when accumulator smaller
// RULE_03 - Equal flag when operands match
// RULE_04 - Greater-than flag when accumulator larger
// RULE_05 - Exactly one comparison flag set
// RULE_06 - Double compare uses all 32 bits
// RULE_07 - Double immediate accepts up to eight hex digits
// RULE_08 - Bitfield count limited to one..thirty-two
// RULE_09 - Bitfield uses start address and count
// RULE_10 - Bits packed right-justified, zero-filled
// RULE_11 - Stack compare uses top stack level
// RULE_12 - Stack compare leaves accumulator unchanged
// RULE_13 - Load pushes old accumulator onto stack
// RULE_14 - Flags hold until next compare overwrites
`include "acc_compare_map.vh"
module accumulator_compare_unit (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // Discrete bit image, bit n is discrete address n
   input  wire [31:0] discrete_i,
   // Flags and interrupt
   output reg         less_than_flag_o,
   output reg         equal_flag_o,
   output reg         greater_than_flag_o,
   output wire        irq_o
);
   reg  [31:0] acc;
   reg  [31:0] operand;
   reg  [13:0] bf_ctrl;
   reg  [31:0] stack [0:`STACK_DEPTH-1];
   reg         bad_count;
   reg  [1:0]  irq_stat;
   reg  [1:0]  irq_mask;
   reg  [31:0] disc_meta;
   reg  [31:0] disc_sync;
   reg  [2:0]  op;
   reg         go;
   reg  [31:0] cmp_a;
   reg  [31:0] cmp_b;
   reg  [31:0] bf_value;
   reg  [31:0] shifted;
   wire        lt;
   wire        eq;
   wire        gt;
   wire        acc_w;
   wire        take;
   wire        wr;
   wire        rd;
   wire [4:0]  bf_start;
   wire [5:0]  bf_cnt;
   wire        cnt_ok;
   reg  [1:0]  next_evt;
   wire        wr_ctrl;
   wire        wr_operand;
   wire        wr_bitfield;
   wire        wr_acc;
   wire        wr_stack_top;
   wire        wr_mask;
   wire        rd_irq_stat;
   wire        cmp_op;
   wire [31:0] operand_merged;
   wire [31:0] bf_merged;
   wire [31:0] acc_merged;
   wire [31:0] top_merged;
   wire [31:0] status_word;
   integer     i;
   integer     k;

   assign take     = cyc_i & stb_i & ~ack_o;
   assign wr       = take & we_i;
   assign rd       = take & ~we_i;
   assign bf_start = bf_ctrl[`BF_START_MSB:`BF_START_LSB];
   assign bf_cnt   = bf_ctrl[`BF_CNT_MSB:`BF_CNT_LSB];
   assign cnt_ok   = (bf_cnt >= `BF_CNT_MIN) && (bf_cnt <= `BF_CNT_MAX); // see RULE_08
   assign irq_o    = |(irq_stat & irq_mask);

   // Register strobes; a write lands on the edge that takes the request
   assign wr_ctrl      = wr && (adr_i == `REG_CTRL) && sel_i[0];
   assign wr_operand   = wr && (adr_i == `REG_OPERAND);
   assign wr_bitfield  = wr && (adr_i == `REG_BITFIELD);
   assign wr_acc       = wr && (adr_i == `REG_ACC);
   assign wr_stack_top = wr && (adr_i == `REG_STACK_TOP);
   assign wr_mask      = wr && (adr_i == `REG_IRQ_MASK) && sel_i[0];
   assign rd_irq_stat  = rd && (adr_i == `REG_IRQ_STAT);

   // Control and mask writes need only byte lane 0; byte lanes merged for data registers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  s;
      begin
         merge = {s[3] ? nw[31:24] : old[31:24], s[2] ? nw[23:16] : old[23:16],
                  s[1] ? nw[15:8]  : old[15:8],  s[0] ? nw[7:0]   : old[7:0]};
      end
   endfunction

   assign operand_merged = merge(operand, dat_i, sel_i);
   assign bf_merged      = merge({{(`ACC_W-`BF_CNT_MSB-1){1'b0}}, bf_ctrl}, dat_i, sel_i);
   assign acc_merged     = merge(acc, dat_i, sel_i);
   assign top_merged     = merge(stack[0], dat_i, sel_i);

   // Status word seen by software
   assign status_word[`FLG_LT]             = less_than_flag_o;
   assign status_word[`FLG_EQ]             = equal_flag_o;
   assign status_word[`FLG_GT]             = greater_than_flag_o;
   assign status_word[`FLG_BAD]            = bad_count;
   assign status_word[`ACC_W-1:`FLG_BAD+1] = 28'h0000000;

   // Discrete bits come from outside this clock's logic
   always @(posedge clk_i) begin
      if (rst_i) begin
         disc_meta <= `ZERO32;
         disc_sync <= `ZERO32;
      end else begin
         disc_meta <= discrete_i;
         disc_sync <= disc_meta;
      end
   end

   // Bitfield packing
   always @* begin
      shifted = disc_sync >> bf_start; // see RULE_09
      // Bits above the count stay zero
      bf_value = `ZERO32;
      for (i = 0; i < `ACC_W; i = i + 1) begin
         if (i < bf_cnt)
            bf_value[i] = shifted[i]; // see RULE_10
      end
   end

   // Operand selection
   always @* begin
      cmp_a = acc;
      cmp_b = operand;
      case (op)
         `OP_WORD: begin
            cmp_a = {16'h0000, acc[`WORD_W-1:0]};     // see RULE_01
            cmp_b = {16'h0000, operand[`WORD_W-1:0]}; // see RULE_01
         end
         `OP_DOUBLE: begin
            cmp_b = operand; // see RULE_06, RULE_07
         end
         `OP_BITFIELD: begin
            cmp_b = bf_value; // see RULE_08
         end
         `OP_STACK: begin
            cmp_b = stack[0]; // see RULE_11
         end
         `OP_NONE, `OP_LOAD: begin
            cmp_b = operand;
         end
         default: begin
            cmp_b = operand;
         end
      endcase
   end

   magnitude_cmp u_cmp (
      .a_i  (cmp_a),
      .b_i  (cmp_b),
      .lt_o (lt),
      .eq_o (eq),
      .gt_o (gt)
   );

   // Command capture: one-cycle execute after a control write
   always @(posedge clk_i) begin
      if (rst_i) begin
         op <= `OP_NONE;
         go <= 1'b0;
      end else begin
         go <= wr_ctrl;
         if (wr_ctrl)
            op <= dat_i[`CTRL_OP_MSB:`CTRL_OP_LSB];
      end
   end

   assign acc_w = go && (op == `OP_LOAD);
   // Only the four compare opcodes touch the flags
   assign cmp_op = go && (op >= `OP_WORD) && (op <= `OP_STACK);

   // Execute
   always @* begin
      next_evt = 2'b00;
      if (cmp_op) begin
         next_evt[`EVT_DONE] = 1'b1;
         if (op == `OP_BITFIELD && !cnt_ok)
            next_evt[`EVT_BADCNT] = 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         less_than_flag_o    <= 1'b0;
         equal_flag_o        <= 1'b0;
         greater_than_flag_o <= 1'b0;
         bad_count           <= 1'b0;
      end else if (next_evt[`EVT_DONE]) begin
         // Flags keep their value until the next compare, except a bitfield compare with a bad count; see RULE_14
         if (next_evt[`EVT_BADCNT]) begin
            bad_count <= 1'b1;
         end else begin
            less_than_flag_o    <= lt; // see RULE_02, RULE_05
            equal_flag_o        <= eq; // see RULE_03, RULE_05
            greater_than_flag_o <= gt; // see RULE_04, RULE_05
            bad_count           <= 1'b0;
         end
      end
   end

   // Accumulator and stack; compares never write them
   always @(posedge clk_i) begin
      if (rst_i) begin
         acc <= `ZERO32;
         for (k = 0; k < `STACK_DEPTH; k = k + 1)
            stack[k] <= `ZERO32;
      end else if (acc_w) begin
         acc      <= operand;
         stack[0] <= acc; // see RULE_13
         // Deepest entry drops off the bottom
         for (k = 1; k < `STACK_DEPTH; k = k + 1)
            stack[k] <= stack[k-1];
      end else if (wr_acc) begin
         acc <= acc_merged; // see RULE_12
      end else if (wr_stack_top) begin
         stack[0] <= top_merged;
      end
   end

   // Compare operand: word, double or immediate value
   always @(posedge clk_i) begin
      if (rst_i)
         operand <= `ZERO32;
      else if (wr_operand)
         operand <= operand_merged; // see RULE_07
   end

   // Bitfield start and count
   always @(posedge clk_i) begin
      if (rst_i)
         bf_ctrl <= `BF_RESET;
      else if (wr_bitfield)
         bf_ctrl <= bf_merged[`BF_CNT_MSB:`BF_START_LSB];
   end

   // Interrupt enables
   always @(posedge clk_i) begin
      if (rst_i)
         irq_mask <= 2'h0;
      else if (wr_mask)
         irq_mask <= dat_i[`EVT_BADCNT:`EVT_DONE];
   end

   // Sticky interrupt status, cleared by read, set wins
   always @(posedge clk_i) begin
      if (rst_i)
         irq_stat <= 2'h0;
      else if (rd_irq_stat)
         irq_stat <= next_evt;
      else
         irq_stat <= irq_stat | next_evt;
   end

   // Bus answer: one-cycle ack
   always @(posedge clk_i) begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= take;
   end

   // Read data, zero for unmapped addresses
   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= `ZERO32;
      end else if (rd) begin
         case (adr_i)
            `REG_CTRL:      dat_o <= {29'h0, op};
            `REG_OPERAND:   dat_o <= operand;
            `REG_BITFIELD:  dat_o <= {{(`ACC_W-`BF_CNT_MSB-1){1'b0}}, bf_ctrl};
            `REG_ACC:       dat_o <= acc;
            `REG_STACK_TOP: dat_o <= stack[0];
            `REG_STACK_D1:  dat_o <= stack[1];
            `REG_STATUS:    dat_o <= status_word;
            `REG_IRQ_STAT:  dat_o <= {30'h0, irq_stat};
            `REG_IRQ_MASK:  dat_o <= {30'h0, irq_mask};
            default:        dat_o <= `ZERO32;
         endcase
      end
   end
endmodule // accumulator_compare_unit

// File: acu_asserts.sv
module acu_chk (
   input logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input logic [7:0]  adr_i,
   input logic [3:0]  sel_i,
   input logic [31:0] dat_i, dat_o,
   input logic        less_than_flag_o, equal_flag_o, greater_than_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire [2:0] f = {greater_than_flag_o, equal_flag_o, less_than_flag_o};
   wire       tk = cyc_i && stb_i && !ack_o;
   wire       ctl = tk && we_i && adr_i == 8'h00;
   // Control write carrying a compare opcode
   wire       cw = ctl && sel_i[0] && dat_i[2:0] != 3'h0 && dat_i[2:0] < 3'h5;
   sequence s_rd; tk && !we_i; endsequence
   property p_take; tk |=> ack_o; endproperty
   a_take: assert property (p_take) else $error("no ack");
   property p_pulse; ack_o |=> !ack_o; endproperty
   a_pulse: assert property (p_pulse) else $error("long ack");
   property p_src; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_src: assert property (p_src) else $error("stray ack");
   property p_one; $onehot0(f); endproperty
   a_one: assert property (p_one) else $error("two flags");
   property p_cause; $changed(f) |-> $past(cw, 2); endproperty
   a_cause: assert property (p_cause) else $error("flags moved");
   property p_hold; ctl && !cw |-> ##2 $stable(f); endproperty
   a_hold: assert property (p_hold) else $error("flags not held");
   property p_stat; s_rd ##0 adr_i == 8'h14 |=> dat_o[2:0] == f; endproperty
   a_stat: assert property (p_stat) else $error("status mismatch");
   property p_unmap; s_rd ##0 adr_i > 8'h20 |=> dat_o == 32'h00000000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
endmodule // acu_chk
bind accumulator_compare_unit acu_chk i_acu_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
   .ack_o, .adr_i, .sel_i, .dat_i, .dat_o, .less_than_flag_o, .equal_flag_o,
   .greater_than_flag_o);

// File: magnitude_cmp.v
`include "acc_compare_map.vh"
module magnitude_cmp (
   // Operands
   input  wire [31:0] a_i,
   input  wire [31:0] b_i,
   // Result
   output wire        lt_o,
   output wire        eq_o,
   output wire        gt_o
);
   assign lt_o = (a_i < b_i);  // see RULE_02
   assign eq_o = (a_i == b_i); // see RULE_03
   assign gt_o = (a_i > b_i);  // see RULE_04
endmodule // magnitude_cmp

// File: tb_accumulator_compare_unit.sv
module tb_accumulator_compare_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, discrete_i = 32'hF0000F30, rd_v;
   wire  [31:0] dat_o;
   wire         ack_o, lt, eq, gt, irq_o;
   int          err_total = 0, comparisons = 0;
   always #2.5 clk_i = ~clk_i;
   accumulator_compare_unit i_accumulator_compare_unit (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .discrete_i, .irq_o,
      .less_than_flag_o(lt), .equal_flag_o(eq), .greater_than_flag_o(gt));
   task automatic chk(input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) begin
         err_total++;
         summarize();
      end else begin
         rd_v = dat_o;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd_v, e);
   endtask
   // Start an operation, then let the flag update land
   task automatic cmp(input logic [2:0] op, e);
      wr(8'h00, {29'h0, op});
      @(posedge clk_i);
      chk({29'h0, gt, eq, lt}, {29'h0, e});
   endtask
   task automatic t(input logic [7:0] a, input logic [31:0] v, input logic [2:0] op, e);
      wr(a, v);
      cmp(op, e);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h14, 32'h0);
      rd(8'h40, 32'h0);
      wr(8'h0C, 32'h12345678);
      t(8'h04, 32'hFFFF5678, 3'h1, 3'h2);
      t(8'h04, 32'h00005679, 3'h1, 3'h1);
      t(8'h04, 32'hFFFF1234, 3'h1, 3'h4);
      t(8'h04, 32'h02345678, 3'h2, 3'h4);
      t(8'h04, 32'h92345678, 3'h2, 3'h1);
      $display("word and double done");
      wr(8'h0C, 32'h000000F3);
      t(8'h08, 32'h00000804, 3'h3, 3'h2);
      t(8'h08, 32'h00002000, 3'h3, 3'h1);
      t(8'h08, 32'h00000000, 3'h3, 3'h1);
      rd(8'h14, 32'h9);
      t(8'h08, 32'h0000081C, 3'h3, 3'h4);
      t(8'h08, 32'h00002104, 3'h3, 3'h4);
      rd(8'h18, 32'h3);
      chk({31'h0, irq_o}, 32'h0);
      rd(8'h18, 32'h0);
      $display("bitfield done");
      wr(8'h0C, 32'h33333333);
      t(8'h04, 32'h22222222, 3'h5, 3'h4);
      rd(8'h10, 32'h33333333);
      cmp(3'h4, 3'h1);
      rd(8'h0C, 32'h22222222);
      t(8'h10, 32'h11111111, 3'h4, 3'h4);
      t(8'h04, 32'h44444444, 3'h5, 3'h4);
      rd(8'h20, 32'h11111111);
      $display("stack done");
      xfer(1'b0, 8'h18, 32'h0);
      wr(8'h1C, 32'h1);
      cmp(3'h1, 3'h2);
      chk({31'h0, irq_o}, 32'h1);
      rd(8'h18, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      $display("interrupt done");
      summarize();
   end
endmodule // tb_accumulator_compare_unit
